// ===== common/irs_regs.svh
`ifndef IRS_REGS_SVH
`define IRS_REGS_SVH
// own 7-bit bus address
`define IRS_SLAVE_ADDR 7'h57
// fifo shape for received write bytes
`define IRS_FIFO_DEPTH 32
`define IRS_FIFO_AW 5
`define IRS_DATA_W 8
// register pointer width and reset value
`define IRS_PTR_W 8
`define IRS_PTR_RST 8'h00
`endif

// ===== common/irs_pkg.sv
package irs_pkg;
    typedef enum logic [2:0]
    {
        IRS_IDLE,
        IRS_ADDR,
        IRS_ACK_OUT,
        IRS_RX,
        IRS_TX,
        IRS_ACK_IN,
        IRS_IGNORE
    } irs_state_t;
endpackage

// ===== logic/irs_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module irs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wr_ptr_ff;
    logic [AW:0]      rd_ptr_ff;
    logic             push;
    logic             pop;

    // full and empty from pointer wrap bit
    assign in_ready_o  = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
    assign out_valid_o = (wr_ptr_ff != rd_ptr_ff);
    assign out_data_o  = mem_ff[rd_ptr_ff[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage write
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
    end

    // pointers
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (pop)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== logic/irs_slave.sv
// Operation
// - idle bus has both lines high
// - sda falling while scl high is start
// - sda rising while scl high is stop
// - one bit per scl pulse, sampled high
// - ninth pulse carries low acknowledge
// - device acks writes, master acks reads
// - high sda on ack is nack
// - respond to address 1010111 msb first
// - eighth bit selects write or read
// - start restarts; read drives data out
// - first write byte loads register pointer
// - stop after index writes nothing
// - data bytes write, pointer increments
// - read returns pointer register, increments
// - nack stops device driving data
// - scl input only, sda open drain
`timescale 1ns/10ps
`default_nettype none
`include "irs_regs.svh"
module irs_slave
    import irs_pkg::*;
#(
    parameter int PTR_W = `IRS_PTR_W
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    // two-wire pins
    input  wire logic             scl_i,
    input  wire logic             sda_i,
    output logic                  sda_o,
    output logic                  sda_oe_n_o,
    // register write stream
    output logic                  wr_valid_o,
    input  wire logic             wr_ready_i,
    output logic [PTR_W-1:0]      wr_addr_o,
    output logic [7:0]            wr_data_o,
    // register read port
    output logic [PTR_W-1:0]      rd_addr_o,
    output logic                  rd_req_o,
    input  wire logic [7:0]       rd_data_i,
    // status
    output logic                  busy_o
);
    initial
    begin
        if (PTR_W < 1 || PTR_W > 8)
            $error("pointer width must be 1 to 8");
    end

    logic [1:0]  scl_sync_ff;
    logic [1:0]  sda_sync_ff;
    logic        scl_d_ff;
    logic        sda_d_ff;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    irs_state_t  state_ff;
    logic [3:0]  bit_cnt_ff;
    logic [7:0]  shift_ff;
    logic        rw_ff;
    logic        first_ff;
    logic [PTR_W-1:0] ptr_ff;
    logic        pull_ff;
    logic        fifo_ready;
    logic        push;
    logic        acked_ff;

    // two-flop synchronisers for pins
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_d_ff    <= 1'b1;
            sda_d_ff    <= 1'b1;
        end
        else
        begin
            scl_sync_ff <= {scl_sync_ff[0], scl_i};
            sda_sync_ff <= {sda_sync_ff[0], sda_i};
            scl_d_ff    <= scl_sync_ff[1];
            sda_d_ff    <= sda_sync_ff[1];
        end
    end

    // edge and condition detection
    assign scl_rise  = scl_sync_ff[1] && !scl_d_ff;
    assign scl_fall  = !scl_sync_ff[1] && scl_d_ff;
    assign start_det = scl_sync_ff[1] && scl_d_ff && sda_d_ff && !sda_sync_ff[1];
    assign stop_det  = scl_sync_ff[1] && scl_d_ff && !sda_d_ff && sda_sync_ff[1];
    assign busy_o    = (state_ff != IRS_IDLE);

    // received byte becomes a register write
    assign push      = (state_ff == IRS_RX) && !first_ff && (bit_cnt_ff == 4'h8) && scl_fall;
    assign rd_addr_o = ptr_ff;
    assign rd_req_o  = (state_ff == IRS_TX) && (bit_cnt_ff == 4'h0);

    // protocol sequencer
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_ff   <= IRS_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff   <= 8'h00;
            rw_ff      <= 1'b0;
            first_ff   <= 1'b0;
            acked_ff   <= 1'b0;
        end
        else if (start_det)
        begin
            state_ff   <= IRS_ADDR;
            bit_cnt_ff <= 4'h0;
        end
        else if (stop_det)
            state_ff <= IRS_IDLE;
        else
        begin
            case (state_ff)
                IRS_ADDR:
                begin
                    if (scl_rise)
                    begin
                        shift_ff   <= {shift_ff[6:0], sda_sync_ff[1]};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_ff == 4'h8)
                    begin
                        if (shift_ff[7:1] == `IRS_SLAVE_ADDR)
                        begin
                            state_ff <= IRS_ACK_OUT;
                            rw_ff    <= shift_ff[0];
                            first_ff <= !shift_ff[0];
                        end
                        else
                            state_ff <= IRS_IGNORE;
                    end
                end
                IRS_ACK_OUT:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_ff <= 4'h0;
                        state_ff   <= rw_ff ? IRS_TX : IRS_RX;
                    end
                end
                IRS_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_ff   <= {shift_ff[6:0], sda_sync_ff[1]};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_ff == 4'h8)
                    begin
                        if (!first_ff && !fifo_ready)
                            state_ff <= IRS_IGNORE; // full: leave unacked
                        else
                            state_ff <= IRS_ACK_OUT;
                        first_ff <= 1'b0;
                    end
                end
                IRS_TX:
                begin
                    if (bit_cnt_ff == 4'h0)
                    begin
                        shift_ff   <= rd_data_i;
                        bit_cnt_ff <= 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (bit_cnt_ff == 4'h8)
                            state_ff <= IRS_ACK_IN;
                        else
                        begin
                            shift_ff   <= {shift_ff[6:0], 1'b0};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                    end
                end
                IRS_ACK_IN:
                begin
                    if (scl_rise)
                        acked_ff <= !sda_sync_ff[1];
                    else if (scl_fall)
                    begin
                        bit_cnt_ff <= 4'h0;
                        state_ff   <= acked_ff ? IRS_TX : IRS_IGNORE;
                    end
                end
                default:
                    state_ff <= state_ff;
            endcase
        end
    end

    // register pointer load and advance
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            ptr_ff <= PTR_W'(`IRS_PTR_RST);
        else if (state_ff == IRS_RX && first_ff && bit_cnt_ff == 4'h8 && scl_fall)
            ptr_ff <= shift_ff[PTR_W-1:0];
        else if (push && fifo_ready)
            ptr_ff <= ptr_ff + 1'b1;
        else if (state_ff == IRS_ACK_IN && scl_fall)
            ptr_ff <= ptr_ff + 1'b1;
    end

    // open-drain sda pull, changed only while scl low
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            pull_ff <= 1'b0;
        else if (start_det || stop_det)
            pull_ff <= 1'b0;
        else if (state_ff == IRS_ACK_OUT)
            pull_ff <= 1'b1;
        else if (state_ff == IRS_TX && bit_cnt_ff != 4'h0)
            pull_ff <= !shift_ff[7];
        else
            pull_ff <= 1'b0;
    end

    // open-drain pin: only ever pulls low, never drives high
    assign sda_o      = 1'b0;
    assign sda_oe_n_o = !pull_ff;

    irs_fifo #(
        .WIDTH (PTR_W + 8),
        .DEPTH (`IRS_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .arst_n_i    (arst_n_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   ({ptr_ff, shift_ff}),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  ({wr_addr_o, wr_data_o})
    );

    // protocol checks on what the slave drives
    a_ack_driven: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state_ff == IRS_ACK_OUT) |=> !sda_oe_n_o)
        else $error("ack not driven low");
    a_sda_odrain: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        sda_o == 1'b0)
        else $error("sda driven high");
    a_start_restart: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        start_det |=> state_ff == IRS_ADDR && bit_cnt_ff == 4'h0)
        else $error("start did not restart");
    a_busy_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        start_det |=> busy_o)
        else $error("start not seen as busy");
    a_stop_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        stop_det && !start_det |=> state_ff == IRS_IDLE ##1 sda_oe_n_o)
        else $error("stop did not free bus");
    a_ignore_release: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state_ff == IRS_IGNORE && $past(state_ff == IRS_IGNORE) |-> sda_oe_n_o)
        else $error("sda pulled while ignoring");
    a_nack_release: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state_ff == IRS_ACK_IN && !acked_ff && scl_fall |=> state_ff == IRS_IGNORE ##1 sda_oe_n_o)
        else $error("nack did not release");
    a_ack_released: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state_ff == IRS_ACK_IN |=> sda_oe_n_o)
        else $error("sda pulled during master ack");
    a_index_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state_ff == IRS_RX && first_ff && bit_cnt_ff == 4'h8 && scl_fall && !start_det && !stop_det
        |=> ptr_ff == $past(shift_ff[PTR_W-1:0]) && !$past(push))
        else $error("index not loaded");
    a_write_incr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        push && fifo_ready |=> ptr_ff == $past(ptr_ff) + 1'b1)
        else $error("pointer did not advance");
    a_read_incr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state_ff == IRS_ACK_IN && scl_fall |=> ptr_ff == $past(ptr_ff) + 1'b1)
        else $error("read pointer did not advance");
    a_rd_req_pulse: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        rd_req_o |=> !rd_req_o)
        else $error("read strobe longer than a cycle");
    a_tx_bit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state_ff == IRS_TX && bit_cnt_ff != 4'h0 && !start_det && !stop_det
        |=> sda_oe_n_o == $past(shift_ff[7]))
        else $error("read bit not on sda");
    a_scl_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $changed(sda_oe_n_o) && !$past(start_det) && !$past(stop_det)
        |-> !$past(scl_sync_ff[1]))
        else $error("sda changed while scl high");
    a_addr_match: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        state_ff == IRS_ADDR && scl_fall && bit_cnt_ff == 4'h8 && !start_det && !stop_det
        && shift_ff[7:1] != `IRS_SLAVE_ADDR |=> state_ff == IRS_IGNORE)
        else $error("foreign address accepted");

    // main scenarios reached
    c_write: cover property (@(posedge clk_i) push);
    c_read: cover property (@(posedge clk_i) state_ff == IRS_ACK_IN && scl_fall && acked_ff);
    c_nack: cover property (@(posedge clk_i) state_ff == IRS_ACK_IN && scl_fall && !acked_ff);
    c_ignore: cover property (@(posedge clk_i) state_ff == IRS_IGNORE);
    c_restart: cover property (@(posedge clk_i) start_det && state_ff != IRS_IDLE);
endmodule
`default_nettype wire

// ===== sim/irs_master.sv
`timescale 1ns/10ps
`default_nettype none
module irs_master (
    // two-wire pins, a high drive means released
    output logic      scl_o,
    output logic      sda_o,
    input  wire logic sda_i
);
    // phase lengths: 125 ns bit, long hold after scl fall
    localparam realtime T_HD = 50.0;
    localparam realtime T_SU = 25.0;
    localparam realtime T_HI = 25.0;

    // both lines released at rest
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // start or repeated start; pins move by non-blocking update so
    // a clock edge at the same instant still sees the old level
    task automatic start();
    begin
        #T_HD sda_o <= 1'b1;
        #T_SU scl_o <= 1'b1;
        #T_HI sda_o <= 1'b0;
        #T_HI scl_o <= 1'b0;
    end
    endtask

    // stop leaves the bus idle
    task automatic stop();
    begin
        #T_HD sda_o <= 1'b0;
        #T_SU scl_o <= 1'b1;
        #T_HI sda_o <= 1'b1;
        #T_HI;
    end
    endtask

    // one pulse, data steady while scl high
    task automatic bit_io(input logic b, output logic s);
    begin
        #T_HD sda_o <= b;
        #T_SU scl_o <= 1'b1;
        #T_HI s = sda_i;
        #T_HI scl_o <= 1'b0;
    end
    endtask

    // send a byte msb first, then sample the ninth bit
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
    begin
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    end
    endtask

    // receive a byte, then answer ack or nack
    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic s;
    begin
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(~ack, s);
    end
    endtask
endmodule
`default_nettype wire

// ===== sim/irs_slave_test.sv
`timescale 1ns/10ps
`default_nettype none
module irs_slave_test;
    logic       clk_i, arst_n_i, wr_ready_i, scl, sda_m, sda_w, sda_o, sda_oe_n_o;
    logic       wr_valid_o, rd_req_o, busy_o, ack;
    logic [7:0] wr_addr_o, wr_data_o, rd_addr_o, rd_data_i, d;
    int         failures, n_tests, n_req;

    // wired-and line with pull-up
    assign sda_w     = sda_m & (sda_oe_n_o | sda_o);
    // register file stand-in
    assign rd_data_i = rd_addr_o ^ 8'h5A;

    // count read strobes, one per byte sent
    always @(posedge clk_i)
    begin
        if (rd_req_o === 1'b1)
            n_req++;
    end

    irs_slave u_irs_slave (.clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
        .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .rd_addr_o(rd_addr_o), .rd_req_o(rd_req_o),
        .rd_data_i(rd_data_i), .busy_o(busy_o));
    irs_master u_irs_master (.scl_o(scl), .sda_o(sda_m), .sda_i(sda_w));

    // clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    begin
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    task automatic results();
    begin
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    // take one fifo entry and compare it
    task automatic pop(input logic [7:0] a, input logic [7:0] v);
        int n;
    begin
        n = 0;
        @(negedge clk_i);
        while (wr_valid_o !== 1'b1 && n < 20)
        begin
            n++;
            @(negedge clk_i);
        end
        chk("wr entry", {a, v}, {wr_addr_o, wr_data_o});
        @(posedge clk_i) wr_ready_i <= 1'b1;
        @(posedge clk_i) wr_ready_i <= 1'b0;
    end
    endtask

    task automatic put_ok(input logic [7:0] b, input logic exp);
    begin
        u_irs_master.put_byte(b, ack);
        chk("ack", {15'h0000, exp}, {15'h0000, ack});
    end
    endtask

    task automatic get_chk(input logic a, input logic [7:0] exp);
    begin
        u_irs_master.get_byte(a, d);
        chk("read byte", {8'h00, exp}, {8'h00, d});
    end
    endtask

    task automatic t_write();
    begin
        u_irs_master.start();
        repeat (2) @(negedge clk_i);
        chk("busy", 16'h0001, {15'h0000, busy_o});
        put_ok(8'hAE, 1'b1);
        put_ok(8'hFE, 1'b1);
        put_ok(8'h11, 1'b1);
        put_ok(8'h22, 1'b1);
        put_ok(8'h33, 1'b1);
        u_irs_master.stop();
        repeat (10) @(negedge clk_i);
        chk("busy", 16'h0000, {15'h0000, busy_o});
        pop(8'hFE, 8'h11);
        pop(8'hFF, 8'h22);
        pop(8'h00, 8'h33);
    end
    endtask

    task automatic t_index_read();
        int base;
    begin
        base = n_req;
        u_irs_master.start();
        put_ok(8'hAE, 1'b1);
        put_ok(8'h10, 1'b1);
        u_irs_master.stop();
        repeat (10) @(negedge clk_i);
        chk("wr_valid", 16'h0000, {15'h0000, wr_valid_o});
        u_irs_master.start();
        put_ok(8'hAF, 1'b1);
        get_chk(1'b1, 8'h4A);
        get_chk(1'b0, 8'h4B);
        repeat (8) @(negedge clk_i);
        chk("sda released", 16'h0001, {15'h0000, sda_oe_n_o});
        chk("rd_req count", 16'h0002, 16'(n_req - base));
        u_irs_master.stop();
        u_irs_master.start();
        put_ok(8'hAE, 1'b1);
        put_ok(8'h7F, 1'b1);
        u_irs_master.start();
        put_ok(8'hAF, 1'b1);
        get_chk(1'b1, 8'h25);
        get_chk(1'b1, 8'hDA);
        get_chk(1'b0, 8'hDB);
        u_irs_master.stop();
        chk("rd_req count", 16'h0005, 16'(n_req - base));
    end
    endtask

    task automatic t_wrong();
    begin
        u_irs_master.start();
        put_ok(8'h56, 1'b0);
        put_ok(8'h00, 1'b0);
        u_irs_master.stop();
        repeat (10) @(negedge clk_i);
        chk("wr_valid", 16'h0000, {15'h0000, wr_valid_o});
    end
    endtask

    // fill until refused while the consumer stalls, then drain
    task automatic t_full();
    begin
        u_irs_master.start();
        put_ok(8'hAE, 1'b1);
        put_ok(8'h40, 1'b1);
        for (int i = 0; i < 32; i++)
            put_ok(8'(i), 1'b1);
        put_ok(8'hEE, 1'b0);
        u_irs_master.stop();
        for (int i = 0; i < 32; i++)
            pop(8'(8'h40 + i), 8'(i));
        repeat (4) @(negedge clk_i);
        chk("wr_valid", 16'h0000, {15'h0000, wr_valid_o});
    end
    endtask

    // main sequence
    initial
    begin
        failures = 0;
        n_tests = 0;
        n_req = 0;
        arst_n_i = 1'b0;
        wr_ready_i = 1'b0;
        repeat (8) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (5) @(negedge clk_i);
        chk("idle", 16'h0001, {14'h0000, busy_o, sda_oe_n_o});
        t_write();
        t_index_read();
        t_wrong();
        t_full();
        results();
    end

    // watchdog
    initial
    begin
        #400000;
        failures++;
        results();
    end
endmodule
`default_nettype wire
